/* File: ihd_pkg.sv */
// Constants, offsets and field layout of the interrupt and halt dispatch unit
// How it works
// - Register 15 holds the address of the next instruction byte.
// - Register 14 is the stack pointer, top of the processor stack.
// - Register 13 is the frame pointer, base of the call frame.
// - Register 12 is the argument pointer, base of the argument list.
// - Internal register numbers decode into five groups: normal and four cache blocks.
// - The backup-cache deallocate block is write-only; a write frees that block.
// - Backup tag, primary tag and primary parity blocks are readable and writable.
// - A nonmaskable interrupt saves counter, status, mapping bit and halt code.
// - The halt procedure sets the priority level to 1F.
// - The halt procedure jumps to the firmware entry, not a vector.
// - A nonmaskable interrupt is taken whatever the current priority level.
// - A maskable interrupt saves counter and status before its handler.
// - A maskable interrupt sets the priority level to its own level.
// - The handler address is fetched from the interrupt's control block entry.
// - The external halt line acts as a level 1F nonmaskable interrupt.
// - An external or nonmaskable halt records halt code 2.
// - Internal registers other than PC, SP, FP, AP and the status are reachable only in kernel mode.
// - Without privilege only status bits 15 to 0 are accessible.
`default_nettype none
package ihd_pkg;
    localparam int IHD_ADDR_W = 12;
    localparam int IHD_DATA_W = 32;

    // Access groups in address bits 10:8
    typedef enum logic [2:0] {
        IHD_GRP_NORMAL = 3'h0,
        IHD_GRP_BTAG = 3'h1,
        IHD_GRP_BDEALLOC = 3'h2,
        IHD_GRP_PTAG = 3'h3,
        IHD_GRP_PPARITY = 3'h4
    } ihd_grp_t;

    // Normal group register indexes
    localparam logic [7:0] IHD_REG_PC = 8'h00;
    localparam logic [7:0] IHD_REG_SP = 8'h01;
    localparam logic [7:0] IHD_REG_FP = 8'h02;
    localparam logic [7:0] IHD_REG_AP = 8'h03;
    localparam logic [7:0] IHD_REG_PS = 8'h04;
    localparam logic [7:0] IHD_REG_HALT_PC = 8'h05;
    localparam logic [7:0] IHD_REG_HALT_PS = 8'h06;
    localparam logic [7:0] IHD_REG_HALT_MAP_EN = 8'h07;
    localparam logic [7:0] IHD_REG_HALT_CODE = 8'h08;
    localparam logic [7:0] IHD_REG_SAVED_PC = 8'h09;
    localparam logic [7:0] IHD_REG_SAVED_PS = 8'h0a;
    localparam logic [7:0] IHD_REG_VTB_BASE = 8'h0b;
    localparam logic [7:0] IHD_REG_MAP_EN = 8'h0c;
    localparam logic [7:0] IHD_REG_INT_STAT = 8'h0d;
    localparam logic [7:0] IHD_REG_INT_MASK = 8'h0e;
    localparam logic [7:0] IHD_REG_DISP_STATE = 8'h0f;

    // Status longword layout
    localparam int IHD_PS_PRIO_LSB = 16;
    localparam int IHD_PRIO_W = 5;
    localparam logic [31:0] IHD_PS_USER_MASK = 32'h0000_ffff;
    localparam logic [31:0] IHD_PS_RESET = 32'h001f_0000;
    localparam logic [4:0] IHD_PRIO_HALT = 5'h1f;
    localparam logic [7:0] IHD_HALT_CODE_EXT = 8'h02;

    // Maskable request lines: line i sits at level base + i
    localparam logic [4:0] IHD_IRQ_BASE_LVL = 5'h14;
    localparam logic [4:0] IHD_IRQ_MAX_LVL = 5'h1e;
    localparam logic [31:0] IHD_IRQ_VEC_BASE = 32'h0000_00d0;
    localparam logic [31:0] IHD_VTB_RESET = 32'h0000_0000;

    // Sticky event bits
    localparam int IHD_EV_HALT = 0;
    localparam int IHD_EV_IRQ = 1;
    localparam int IHD_EV_PRIV = 2;
    localparam int IHD_EV_DEALLOC = 3;
    localparam int IHD_EV_W = 4;
endpackage : ihd_pkg
`default_nettype wire

/* File: ihd_ipr_block.sv */
// Directly accessible storage block for cache tag or parity registers
`timescale 1ns/100ps
`default_nettype none
module ihd_reg_block #(
    parameter int DEPTH = 16,
    parameter int WIDTH = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic clr_en,
    input wire logic [$clog2(DEPTH)-1:0] idx,
    input wire logic [WIDTH-1:0] wr_data,
    output logic [WIDTH-1:0] rd_data
);
    // Index width must cover the depth exactly
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
        $error("ihd_reg_block: DEPTH must be a power of two");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];

    // Write stores, clear drops the entry; clear wins as it frees the block
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else if (clr_en) begin
            mem_q[idx] <= '0;
        end else if (wr_en) begin
            mem_q[idx] <= wr_data;
        end
    end

    // Read is combinational; the caller registers it
    assign rd_data = mem_q[idx];
endmodule : ihd_reg_block
`default_nettype wire

/* File: ihd_dispatch.sv */
// Interrupt entry, halt procedure and internal register access unit
`timescale 1ns/100ps
`default_nettype none
module ihd_dispatch #(
    parameter int NUM_IRQ = 4,
    parameter int BTAG_DEPTH = 16,
    parameter int PTAG_DEPTH = 16,
    parameter int PPAR_DEPTH = 16,
    parameter int PPAR_W = 8,
    parameter logic [31:0] FW_ENTRY = 32'h0000_1000
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [ihd_pkg::IHD_ADDR_W-1:0] addr,
    input wire logic [ihd_pkg::IHD_DATA_W-1:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [ihd_pkg::IHD_DATA_W-1:0] rd_data,
    input wire logic kernel_mode,
    input wire logic halt_req,
    input wire logic [NUM_IRQ-1:0] irq_req,
    output logic [NUM_IRQ-1:0] irq_ack,
    output logic vec_req,
    output logic [31:0] vec_addr,
    input wire logic vec_ack,
    input wire logic [31:0] vec_data,
    output logic halt_entry,
    output logic handler_entry,
    output logic irq_out
);
    import ihd_pkg::*;

    // Request lines must stay below the halt level
    if (NUM_IRQ < 1 || NUM_IRQ > 11 || PPAR_W < 1 || PPAR_W > 31) begin : g_bad
        $error("ihd_dispatch: NUM_IRQ must be 1..11, PPAR_W 1..31");
    end

    typedef enum logic [1:0] {
        IHD_ST_IDLE = 2'b00,
        IHD_ST_FETCH = 2'b01,
        IHD_ST_WAIT = 2'b10
    } ihd_state_t;

    logic [1:0] rst_sync_q;
    logic rst_n;
    ihd_state_t state_q;
    logic [31:0] pc_q, sp_q, fp_q, ap_q, ps_q;
    logic [31:0] halt_pc_q, halt_ps_q, saved_pc_q, saved_ps_q, vtb_base_q;
    logic halt_map_en_q, map_en_q;
    logic [7:0] halt_code_q;
    logic [IHD_EV_W-1:0] stat_q, mask_q, ev;
    logic halt_req_q;
    logic [4:0] take_lvl_q;
    logic [31:0] take_off_q;
    logic [31:0] rd_data_q, vec_addr_q;
    logic [NUM_IRQ-1:0] irq_ack_q;
    logic vec_req_q, halt_entry_q, handler_entry_q, irq_out_q;

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // Address decode into the five access groups
    ihd_grp_t grp;
    logic [7:0] idx;
    logic is_open, acc_ok, wr_ok, rd_ok;
    assign grp = ihd_grp_t'(addr[10:8]);
    assign idx = addr[7:0];
    // General registers and the low status half need no privilege
    assign is_open = (grp == IHD_GRP_NORMAL) && (idx <= IHD_REG_PS);
    assign acc_ok = kernel_mode || is_open;
    assign wr_ok = wr_en && acc_ok;
    assign rd_ok = rd_en && acc_ok;

    logic nrm_wr, btag_wr, bdea_wr, ptag_wr, ppar_wr;
    assign nrm_wr = wr_ok && (grp == IHD_GRP_NORMAL);
    assign btag_wr = wr_ok && (grp == IHD_GRP_BTAG);
    assign bdea_wr = wr_ok && (grp == IHD_GRP_BDEALLOC);
    assign ptag_wr = wr_ok && (grp == IHD_GRP_PTAG);
    assign ppar_wr = wr_ok && (grp == IHD_GRP_PPARITY);

    // Cache register blocks, addressed by the low index bits
    logic [31:0] btag_rd, ptag_rd;
    logic [PPAR_W-1:0] ppar_rd;
    ihd_reg_block #(.DEPTH(BTAG_DEPTH), .WIDTH(32)) u_btag (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(btag_wr),
        .clr_en(bdea_wr),
        .idx(idx[$clog2(BTAG_DEPTH)-1:0]),
        .wr_data(wr_data),
        .rd_data(btag_rd)
    );
    ihd_reg_block #(.DEPTH(PTAG_DEPTH), .WIDTH(32)) u_ptag (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(ptag_wr),
        .clr_en(1'b0),
        .idx(idx[$clog2(PTAG_DEPTH)-1:0]),
        .wr_data(wr_data),
        .rd_data(ptag_rd)
    );
    ihd_reg_block #(.DEPTH(PPAR_DEPTH), .WIDTH(PPAR_W)) u_ppar (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(ppar_wr),
        .clr_en(1'b0),
        .idx(idx[$clog2(PPAR_DEPTH)-1:0]),
        .wr_data(wr_data[PPAR_W-1:0]),
        .rd_data(ppar_rd)
    );

    // Arbitration: pick the highest eligible request line
    logic [4:0] prio;
    logic take_nmi, take_irq, any_elig;
    logic [4:0] win_lvl;
    logic [31:0] win_off;
    logic [NUM_IRQ-1:0] win_onehot;
    assign prio = ps_q[IHD_PS_PRIO_LSB +: IHD_PRIO_W];
    always_comb begin
        any_elig = 1'b0;
        win_lvl = '0;
        win_off = '0;
        win_onehot = '0;
        // Later lines carry higher levels, so the last hit wins
        for (int i = 0; i < NUM_IRQ; i++) begin
            if (irq_req[i] && (IHD_IRQ_BASE_LVL + 5'(i)) > prio) begin
                any_elig = 1'b1;
                win_lvl = IHD_IRQ_BASE_LVL + 5'(i);
                win_off = IHD_IRQ_VEC_BASE + (32'(i) << 2);
                win_onehot = '0;
                win_onehot[i] = 1'b1;
            end
        end
    end
    // Halt is taken on its rising edge in any state, ignoring level
    assign take_nmi = halt_req && !halt_req_q;
    assign take_irq = !take_nmi && (state_q == IHD_ST_IDLE) && any_elig;

    // Edge detector for the halt line
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            halt_req_q <= 1'b0;
        end else begin
            halt_req_q <= halt_req;
        end
    end

    // Dispatch sequence: save, fetch vector, enter handler
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= IHD_ST_IDLE;
            take_lvl_q <= '0;
            take_off_q <= '0;
        end else if (take_nmi) begin
            // Halt aborts any vector fetch in flight
            state_q <= IHD_ST_IDLE;
        end else begin
            case (state_q)
                IHD_ST_IDLE: begin
                    if (take_irq) begin
                        take_lvl_q <= win_lvl;
                        take_off_q <= win_off;
                        state_q <= IHD_ST_FETCH;
                    end
                end
                IHD_ST_FETCH: state_q <= IHD_ST_WAIT;
                IHD_ST_WAIT: begin
                    if (vec_ack) begin
                        state_q <= IHD_ST_IDLE;
                    end
                end
                default: state_q <= IHD_ST_IDLE;
            endcase
        end
    end

    // Vector fetch request to the control block
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vec_req_q <= 1'b0;
            vec_addr_q <= '0;
        end else if (take_nmi || (state_q == IHD_ST_WAIT && vec_ack)) begin
            vec_req_q <= 1'b0;
        end else if (state_q == IHD_ST_FETCH) begin
            vec_req_q <= 1'b1;
            vec_addr_q <= vtb_base_q + take_off_q;
        end
    end

    // Program counter: halt entry, handler entry, then software
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_q <= '0;
        end else if (take_nmi) begin
            pc_q <= FW_ENTRY;
        end else if (state_q == IHD_ST_WAIT && vec_ack) begin
            pc_q <= vec_data;
        end else if (nrm_wr && idx == IHD_REG_PC) begin
            pc_q <= wr_data;
        end
    end

    // Stack, frame and argument pointers are software owned
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sp_q <= '0;
            fp_q <= '0;
            ap_q <= '0;
        end else if (nrm_wr) begin
            if (idx == IHD_REG_SP) sp_q <= wr_data;
            if (idx == IHD_REG_FP) fp_q <= wr_data;
            if (idx == IHD_REG_AP) ap_q <= wr_data;
        end
    end

    // Status longword; entries override software writes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ps_q <= IHD_PS_RESET;
        end else if (take_nmi) begin
            ps_q[IHD_PS_PRIO_LSB +: IHD_PRIO_W] <= IHD_PRIO_HALT;
        end else if (take_irq) begin
            ps_q[IHD_PS_PRIO_LSB +: IHD_PRIO_W] <= win_lvl;
        end else if (nrm_wr && idx == IHD_REG_PS) begin
            // Without privilege the upper half keeps its value
            ps_q <= kernel_mode ? wr_data
                  : ((ps_q & ~IHD_PS_USER_MASK) | (wr_data & IHD_PS_USER_MASK));
        end
    end

    // State saved by the halt procedure
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            halt_pc_q <= '0;
            halt_ps_q <= '0;
            halt_map_en_q <= 1'b0;
            halt_code_q <= '0;
        end else if (take_nmi) begin
            halt_pc_q <= pc_q;
            halt_ps_q <= ps_q;
            halt_map_en_q <= map_en_q;
            halt_code_q <= IHD_HALT_CODE_EXT;
        end else if (nrm_wr && idx == IHD_REG_HALT_CODE) begin
            halt_code_q <= wr_data[7:0];
        end
    end

    // State saved on maskable entry, before the priority is raised
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            saved_pc_q <= '0;
            saved_ps_q <= '0;
        end else if (take_irq) begin
            saved_pc_q <= pc_q;
            saved_ps_q <= ps_q;
        end
    end

    // Control block base and mapping enable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vtb_base_q <= IHD_VTB_RESET;
            map_en_q <= 1'b0;
        end else if (nrm_wr) begin
            if (idx == IHD_REG_VTB_BASE) vtb_base_q <= {wr_data[31:2], 2'b00};
            if (idx == IHD_REG_MAP_EN) map_en_q <= wr_data[0];
        end
    end

    // Acknowledge and entry pulses, one cycle each
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_ack_q <= '0;
            halt_entry_q <= 1'b0;
            handler_entry_q <= 1'b0;
        end else begin
            irq_ack_q <= take_irq ? win_onehot : '0;
            halt_entry_q <= take_nmi;
            handler_entry_q <= !take_nmi && state_q == IHD_ST_WAIT && vec_ack;
        end
    end

    // Events that feed the sticky status
    always_comb begin
        ev = '0;
        ev[IHD_EV_HALT] = take_nmi;
        ev[IHD_EV_IRQ] = take_irq;
        ev[IHD_EV_PRIV] = (wr_en || rd_en) && !acc_ok;
        ev[IHD_EV_DEALLOC] = bdea_wr;
    end

    // Write one to clear; a new event in the same cycle wins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stat_q <= '0;
            mask_q <= '0;
        end else begin
            if (nrm_wr && idx == IHD_REG_INT_STAT) begin
                stat_q <= (stat_q & ~wr_data[IHD_EV_W-1:0]) | ev;
            end else begin
                stat_q <= stat_q | ev;
            end
            if (nrm_wr && idx == IHD_REG_INT_MASK) mask_q <= wr_data[IHD_EV_W-1:0];
        end
    end

    // Interrupt line follows the unmasked status one cycle later
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_out_q <= 1'b0;
        end else begin
            irq_out_q <= |(stat_q & mask_q);
        end
    end

    // Read mux for the normal group
    logic [31:0] nrm_rd;
    always_comb begin
        case (idx)
            IHD_REG_PC: nrm_rd = pc_q;
            IHD_REG_SP: nrm_rd = sp_q;
            IHD_REG_FP: nrm_rd = fp_q;
            IHD_REG_AP: nrm_rd = ap_q;
            IHD_REG_PS: nrm_rd = kernel_mode ? ps_q : (ps_q & IHD_PS_USER_MASK);
            IHD_REG_HALT_PC: nrm_rd = halt_pc_q;
            IHD_REG_HALT_PS: nrm_rd = halt_ps_q;
            IHD_REG_HALT_MAP_EN: nrm_rd = {31'h0, halt_map_en_q};
            IHD_REG_HALT_CODE: nrm_rd = {24'h0, halt_code_q};
            IHD_REG_SAVED_PC: nrm_rd = saved_pc_q;
            IHD_REG_SAVED_PS: nrm_rd = saved_ps_q;
            IHD_REG_VTB_BASE: nrm_rd = vtb_base_q;
            IHD_REG_MAP_EN: nrm_rd = {31'h0, map_en_q};
            IHD_REG_INT_STAT: nrm_rd = {{(32-IHD_EV_W){1'b0}}, stat_q};
            IHD_REG_INT_MASK: nrm_rd = {{(32-IHD_EV_W){1'b0}}, mask_q};
            IHD_REG_DISP_STATE: nrm_rd = {30'h0, state_q};
            default: nrm_rd = '0;
        endcase
    end

    // Read data stands one cycle after the strobe, zero otherwise
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_q <= '0;
        end else if (!rd_ok) begin
            rd_data_q <= '0;
        end else begin
            case (grp)
                IHD_GRP_NORMAL: rd_data_q <= nrm_rd;
                IHD_GRP_BTAG: rd_data_q <= btag_rd;
                IHD_GRP_PTAG: rd_data_q <= ptag_rd;
                IHD_GRP_PPARITY: rd_data_q <= {{(32-PPAR_W){1'b0}}, ppar_rd};
                // Deallocate block has no readable content
                IHD_GRP_BDEALLOC: rd_data_q <= '0;
                default: rd_data_q <= '0;
            endcase
        end
    end

    assign rd_data = rd_data_q;
    assign irq_ack = irq_ack_q;
    assign vec_req = vec_req_q;
    assign vec_addr = vec_addr_q;
    assign halt_entry = halt_entry_q;
    assign handler_entry = handler_entry_q;
    assign irq_out = irq_out_q;
endmodule : ihd_dispatch
`default_nettype wire

/* File: ihd_dispatch_chk.sv */
// Port-level checker for the interrupt and halt dispatch unit
`timescale 1ns/100ps
`default_nettype none
module ihd_dispatch_chk #(
    parameter int NUM_IRQ = 4
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [ihd_pkg::IHD_ADDR_W-1:0] addr,
    input wire logic [ihd_pkg::IHD_DATA_W-1:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [ihd_pkg::IHD_DATA_W-1:0] rd_data,
    input wire logic kernel_mode,
    input wire logic halt_req,
    input wire logic [NUM_IRQ-1:0] irq_req,
    input wire logic [NUM_IRQ-1:0] irq_ack,
    input wire logic vec_req,
    input wire logic [31:0] vec_addr,
    input wire logic vec_ack,
    input wire logic [31:0] vec_data,
    input wire logic halt_entry,
    input wire logic handler_entry,
    input wire logic irq_out
);
    import ihd_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // Acknowledge is one line wide and lasts one cycle
    sequence s_ack_one;
        $onehot(irq_ack);
    endsequence
    sequence s_ack_gone;
        irq_ack == '0;
    endsequence

    property p_halt_take;
        $rose(halt_req) |=> halt_entry;
    endproperty
    a_halt_take: assert property (p_halt_take) else $error("halt edge not taken");
    // Held request must not re-enter the halt path
    property p_halt_edge;
        halt_entry |-> $past(halt_req) && !$past(halt_req, 2);
    endproperty
    a_halt_edge: assert property (p_halt_edge) else $error("halt entry without edge");
    property p_halt_abort;
        halt_entry |=> (!vec_req)[*3];
    endproperty
    a_halt_abort: assert property (p_halt_abort) else $error("vector fetch after halt");
    property p_ack_pulse;
        irq_ack != '0 |-> s_ack_one ##1 s_ack_gone;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("acknowledge shape wrong");
    property p_ack_req;
        irq_ack != '0 |-> (irq_ack & ~$past(irq_req)) == '0;
    endproperty
    a_ack_req: assert property (p_ack_req) else $error("acknowledge without request");
    property p_fetch;
        irq_ack != '0 && !$rose(halt_req) |=> vec_req;
    endproperty
    a_fetch: assert property (p_fetch) else $error("no vector fetch after take");
    property p_vec_hold;
        vec_req && !vec_ack && !$rose(halt_req) |=> vec_req && $stable(vec_addr);
    endproperty
    a_vec_hold: assert property (p_vec_hold) else $error("vector fetch not held");
    property p_handler;
        vec_req && vec_ack && !$rose(halt_req) |=> handler_entry && !vec_req;
    endproperty
    a_handler: assert property (p_handler) else $error("handler not entered");
    property p_dealloc_rd;
        rd_en && addr[10:8] == IHD_GRP_BDEALLOC |=> rd_data == '0;
    endproperty
    a_dealloc_rd: assert property (p_dealloc_rd) else $error("write-only block read back");
    property p_priv_rd;
        rd_en && !kernel_mode && addr[10:8] != 3'h0 |=> rd_data == '0;
    endproperty
    a_priv_rd: assert property (p_priv_rd) else $error("unprivileged read leaked");
endmodule : ihd_dispatch_chk

bind ihd_dispatch ihd_dispatch_chk #(.NUM_IRQ(NUM_IRQ)) i_ihd_dispatch_chk (
    .clk(clk), .nrst(nrst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .kernel_mode(kernel_mode), .halt_req(halt_req), .irq_req(irq_req),
    .irq_ack(irq_ack), .vec_req(vec_req), .vec_addr(vec_addr), .vec_ack(vec_ack),
    .vec_data(vec_data), .halt_entry(halt_entry), .handler_entry(handler_entry), .irq_out(irq_out)
);
`default_nettype wire

/* File: ihd_vec_src.sv */
// Vector table responder standing on the far side of the fetch port
`timescale 1ns/100ps
`default_nettype none
module ihd_vec_src (
    input wire logic clk,
    input wire logic [3:0] delay,
    input wire logic vec_req,
    input wire logic [31:0] vec_addr,
    output logic vec_ack,
    output logic [31:0] vec_data
);
    logic [3:0] wait_q;
    initial begin
        vec_ack = 1'b0;
        vec_data = 32'h0;
        wait_q = 4'h0;
    end
    // Answer after delay cycles; data scrambled outside the ack cycle
    always @(posedge clk) begin
        if (vec_ack || !vec_req) begin
            vec_ack <= 1'b0;
            vec_data <= ~vec_data;
            wait_q <= 4'h0;
        end else if (wait_q == delay) begin
            vec_ack <= 1'b1;
            vec_data <= vec_addr + 32'h0000_8000; // Handler sits at entry address plus offset
        end else begin
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule : ihd_vec_src
`default_nettype wire

/* File: interrupt_halt_dispatch_tb.sv */
// Self-checking bench for the interrupt and halt dispatch unit
`timescale 1ns/100ps
`default_nettype none
module interrupt_halt_dispatch_tb;
    import ihd_pkg::*;
    localparam logic [31:0] FW = 32'h0000_1000;
    logic clk, nrst, wr_en, rd_en, kernel_mode, halt_req;
    logic vec_req, vec_ack, halt_entry, handler_entry, irq_out;
    logic [11:0] addr;
    logic [31:0] wr_data, rd_data, vec_addr, vec_data;
    logic [3:0] irq_req, irq_ack, vec_delay;
    int error_cnt, comparisons, i;

    ihd_dispatch #(.NUM_IRQ(4), .FW_ENTRY(FW)) i_ihd_dispatch (
        .clk(clk), .nrst(nrst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
        .rd_data(rd_data), .kernel_mode(kernel_mode), .halt_req(halt_req), .irq_req(irq_req),
        .irq_ack(irq_ack), .vec_req(vec_req), .vec_addr(vec_addr), .vec_ack(vec_ack),
        .vec_data(vec_data), .halt_entry(halt_entry), .handler_entry(handler_entry), .irq_out(irq_out)
    );
    ihd_vec_src i_ihd_vec_src (
        .clk(clk), .delay(vec_delay), .vec_req(vec_req), .vec_addr(vec_addr),
        .vec_ack(vec_ack), .vec_data(vec_data)
    );

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk(rd_data, exp);
    endtask : rd

    // One maskable take: ack, fetch address, then bounded wait for handler entry
    task automatic take(input logic [3:0] lines, input logic [3:0] ack, input logic [31:0] va);
        int n;
        n = 0;
        @(posedge clk);
        irq_req <= lines;
        cyc(1);
        chk({28'h0, irq_ack}, {28'h0, ack});
        @(posedge clk);
        irq_req <= 4'h0;
        #1;
        chk({31'h0, vec_req}, 32'h1);
        chk(vec_addr, va);
        while (handler_entry !== 1'b1 && n < 40) begin
            cyc(1);
            n++;
        end
        chk({31'h0, handler_entry}, 32'h1);
    endtask : take

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Hang guard, far beyond the expected run
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        report_and_stop();
    end

    initial begin
        nrst = 1'b0;
        addr = 12'h0;
        wr_data = 32'h0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        kernel_mode = 1'b1;
        halt_req = 1'b0;
        irq_req = 4'h0;
        vec_delay = 4'h0;
        error_cnt = 0;
        comparisons = 0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        // Dedicated pointer registers
        for (i = 0; i < 4; i++) begin
            wr(12'(i), 32'ha5a5_0000 + 32'(i));
            rd(12'(i), 32'ha5a5_0000 + 32'(i));
        end
        rd(12'h004, IHD_PS_RESET);
        // Cache blocks, then a deallocate of the written tag
        wr(12'h103, 32'hdead_beef);
        wr(12'h305, 32'h1234_5678);
        wr(12'h402, 32'h0000_01c3);
        rd(12'h103, 32'hdead_beef);
        rd(12'h305, 32'h1234_5678);
        rd(12'h402, 32'h0000_00c3);
        wr(12'h203, 32'h0);
        rd(12'h103, 32'h0);
        rd(12'h203, 32'h0);
        wr(12'h020, 32'hffff_ffff);
        rd(12'h020, 32'h0);
        // Unprivileged access is refused or trimmed
        @(posedge clk);
        kernel_mode <= 1'b0;
        wr(12'h305, 32'h0);
        wr(12'h004, 32'hffff_ffff);
        rd(12'h305, 32'h0);
        rd(12'h004, 32'h0000_ffff);
        @(posedge clk);
        kernel_mode <= 1'b1;
        rd(12'h305, 32'h1234_5678);
        rd(12'h004, 32'h001f_ffff);
        // Sticky status, mask and level output
        rd(12'h00d, 32'h0000_000c);
        wr(12'h00e, 32'h4);
        cyc(2);
        chk({31'h0, irq_out}, 32'h1);
        wr(12'h00d, 32'hf);
        cyc(2);
        chk({31'h0, irq_out}, 32'h0);
        rd(12'h00d, 32'h0);
        wr(12'h00e, 32'h1);
        // Maskable take: highest line wins, state saved, level raised
        wr(12'h00b, 32'h0000_2000);
        wr(12'h004, 32'h0);
        take(4'b1010, 4'b1000, 32'h0000_20dc);
        rd(12'h000, 32'h0000_a0dc);
        rd(12'h004, 32'h0017_0000);
        rd(12'h009, 32'ha5a5_0000);
        rd(12'h00a, 32'h0);
        // Level equal to the current one is held off
        wr(12'h004, 32'h0015_0000);
        @(posedge clk);
        irq_req <= 4'b0010;
        cyc(6);
        chk({31'h0, vec_req}, 32'h0);
        @(posedge clk);
        irq_req <= 4'h0;
        vec_delay <= 4'd6;
        wr(12'h004, 32'h0014_0000);
        take(4'b0010, 4'b0010, 32'h0000_20d4);
        rd(12'h004, 32'h0015_0000);
        // Halt arrives while a slow fetch is pending
        wr(12'h00c, 32'h1);
        @(posedge clk);
        vec_delay <= 4'hf;
        irq_req <= 4'b0100;
        repeat (3) @(posedge clk);
        irq_req <= 4'h0;
        halt_req <= 1'b1;
        cyc(1);
        chk({31'h0, halt_entry}, 32'h1);
        for (i = 0; i < 4; i++) begin
            cyc(1);
            chk({30'h0, halt_entry, vec_req}, 32'h0);
        end
        chk({31'h0, irq_out}, 32'h1);
        rd(12'h000, FW);
        rd(12'h004, 32'h001f_0000);
        rd(12'h005, 32'h0000_a0d4);
        rd(12'h006, 32'h0016_0000);
        rd(12'h007, 32'h1);
        rd(12'h00c, 32'h1);
        rd(12'h00f, 32'h0);
        rd(12'h008, 32'h2);
        @(posedge clk);
        halt_req <= 1'b0;
        cyc(2);
        report_and_stop();
    end
endmodule : interrupt_halt_dispatch_tb
`default_nettype wire
